// ==== bkq_consts.svh ====
// Offsets, field positions, reset value and page bit position for the breakpoint match qualifier.
`ifndef BKQ_CONSTS_SVH
`define BKQ_CONSTS_SVH
`define BKQ_OFF_MASK_RW 4'h0
`define BKQ_OFF_MODE 4'h1
`define BKQ_OFF_A_EXT 4'h2
`define BKQ_OFF_A_HIGH 4'h3
`define BKQ_OFF_A_LOW 4'h4
`define BKQ_OFF_B_EXT 4'h5
`define BKQ_OFF_B_HIGH 4'h6
`define BKQ_OFF_B_LOW 4'h7
`define BKQ_OFF_STATUS 4'h8
`define BKQ_BIT_AMH 7
`define BKQ_BIT_AML 6
`define BKQ_BIT_BMH 5
`define BKQ_BIT_BML 4
`define BKQ_BIT_A_DIR_EN 3
`define BKQ_BIT_A_DIR 2
`define BKQ_BIT_B_DIR_EN 1
`define BKQ_BIT_B_DIR 0
`define BKQ_BIT_MODE_BKP 1
`define BKQ_BIT_MODE_FULL 0
`define BKQ_RST_REG 8'h00
`define BKQ_PAGE_LSB 14
`endif

// ==== bkq_pkg.sv ====
// Types shared by the breakpoint match qualifier.
package bkq_pkg;
  typedef logic [7:0] bkq_byte_t;
  typedef logic [3:0] bkq_addr_t;
  typedef logic [15:0] bkq_word_t;
  typedef logic [5:0] bkq_page_t;
  // One comparator's settings as seen by the matcher.
  typedef struct packed {
    logic [5:0] ext;
    logic [15:0] value;
    logic maskHigh;
    logic maskLow;
    logic dirEn;
    logic dirVal;
    logic dataMode;
  } bkq_cmp_cfg_t;
endpackage

// ==== bkq_cmp_if.sv ====
// Carrier between the register file and one comparator matcher.
`timescale 1ns/1ps
interface bkq_cmp_if;
  import bkq_pkg::*;
  bkq_cmp_cfg_t cfg;
  logic hit;
  modport ctrl (output cfg, input hit);
  modport cmp (input cfg, output hit);
endinterface

// ==== bkq_matcher.sv ====
// One comparator: masked address or data compare with direction qualification.
`timescale 1ns/1ps
module bkq_matcher (
  input wire logic sys_clk, // Core bus clock.
  input wire logic rst_n, // Asynchronous reset, active low.
  bkq_cmp_if.cmp link, // Settings in, match out.
  input wire logic [15:0] busAddr, // Core address bus.
  input wire logic [15:0] busData, // Core data bus.
  input wire logic [5:0] progPage, // Selected program page bits.
  input wire logic pageAccess, // A program page is accessed.
  input wire logic busValid, // A bus access happens this cycle.
  input wire logic busRead // High on read, low on write.
);
  import bkq_pkg::*;
  typedef struct packed {
    logic hit;
  } bkq_mstate_t;
  bkq_mstate_t state_r;
  bkq_mstate_t state_nxt;
  logic extOk;
  logic highOk;
  logic lowOk;
  logic useHigh;
  logic useLow;
  logic dirOk;
  bkq_word_t probe;

  // Field compares; paged accesses swap the top address bits for page bits.
  always_comb begin
    probe = link.cfg.dataMode ? busData : busAddr;
    useHigh = 1'b1;
    useLow = 1'b1;
    extOk = 1'b1;
    if (link.cfg.dataMode) begin
      useHigh = !link.cfg.maskHigh;
      useLow = !link.cfg.maskLow;
      extOk = 1'b1;
    end else begin
      useLow = !link.cfg.maskLow;
      useHigh = !(link.cfg.maskHigh && link.cfg.maskLow);
      extOk = !pageAccess || (link.cfg.ext == progPage);
    end
    lowOk = !useLow || (probe[7:0] == link.cfg.value[7:0]);
    if (!useHigh) begin
      highOk = 1'b1;
    end else if (pageAccess && !link.cfg.dataMode) begin
      highOk = probe[13:8] == link.cfg.value[13:8];
    end else begin
      highOk = probe[15:8] == link.cfg.value[15:8];
    end
    dirOk = !link.cfg.dirEn || (busRead == link.cfg.dirVal);
  end

  // all fields agree in one access
  always_comb begin
    state_nxt.hit = busValid && extOk && highOk && lowOk && dirOk;
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= '0;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign link.hit = state_r.hit;

  property p_dir_blocks;
    @(posedge sys_clk) disable iff (!rst_n)
      (busValid && link.cfg.dirEn && (busRead != link.cfg.dirVal)) |=> !link.hit;
  endproperty
  a_dir_blocks: assert property (p_dir_blocks) else $error("Wrong direction matched.");
  property p_no_access;
    @(posedge sys_clk) disable iff (!rst_n) !busValid |=> !link.hit;
  endproperty
  a_no_access: assert property (p_no_access) else $error("Match without access.");
  property p_page_ext;
    @(posedge sys_clk) disable iff (!rst_n)
      (busValid && !link.cfg.dataMode && pageAccess && link.cfg.ext != progPage) |=> !link.hit;
  endproperty
  a_page_ext: assert property (p_page_ext) else $error("Page mismatch matched.");
  property p_low_byte;
    @(posedge sys_clk) disable iff (!rst_n)
      (busValid && !link.cfg.maskLow && probe[7:0] != link.cfg.value[7:0]) |=> !link.hit;
  endproperty
  a_low_byte: assert property (p_low_byte) else $error("Low byte mismatch matched.");
  property p_full_data;
    @(posedge sys_clk) disable iff (!rst_n)
      (busValid && link.cfg.dataMode && !link.cfg.maskHigh
       && busData[15:8] != link.cfg.value[15:8]) |=> !link.hit;
  endproperty
  a_full_data: assert property (p_full_data) else $error("Data high mismatch matched.");
  property p_unpaged16;
    @(posedge sys_clk) disable iff (!rst_n)
      (busValid && !link.cfg.dataMode && !pageAccess && !link.cfg.maskHigh
       && busAddr[15:14] != link.cfg.value[15:14]) |=> !link.hit;
  endproperty
  a_unpaged16: assert property (p_unpaged16) else $error("16-bit compare missed bits.");
  property p_range16k;
    @(posedge sys_clk) disable iff (!rst_n)
      (busValid && !link.cfg.dataMode && link.cfg.maskHigh && link.cfg.maskLow && pageAccess
       && link.cfg.ext == progPage && !link.cfg.dirEn) |=> link.hit;
  endproperty
  a_range16k: assert property (p_range16k) else $error("Page range did not match.");
endmodule

// ==== bkq_qualifier.sv ====
// Breakpoint A/B match qualifier: control register, compare values and two matchers.
// Operation
// - Bits 7:6 may mask comparator A high and/or low address bytes.
// - Paged full compare: six page bits plus address 13:0.
// - Unpaged full compare: sixteen bits against address 15:0, extended ignored.
// - Mask 1:0 acts as full compare, high mask bit ignored.
// - Mask 0:1 compares page and high byte, 256-byte range.
// - Mask 1:1 compares only page bits, 16K-byte page range.
// - Extended bits join address compares only on program page accesses.
// - In dual mode bits 5:4 mask comparator B like comparator A.
// - In full mode bits 5:4 select which data bytes compare.
// - In full mode comparator B extended bits are never used.
// - Bit 3 enables direction qualification for comparator A.
// - Bit 2 picks A direction: 0 write, 1 read.
// - Bit 1 enables direction qualification for comparator B.
// - Bit 0 picks B direction: 0 write, 1 read.
// - In full mode comparator B direction bits are ignored.
// - In debug mode comparator A mask bits are forced to zero.
// - Full mode: A matches address, B data; dual: both address.
`timescale 1ns/1ps
`include "bkq_consts.svh"
module bkq_qualifier (
  input wire logic sys_clk, // Core bus clock, 20 MHz.
  input wire logic rst_n, // Asynchronous reset, active low.
  input wire bkq_pkg::bkq_addr_t regAddr, // Register index.
  input wire bkq_pkg::bkq_byte_t regWdata, // Register write data.
  input wire logic regWr, // Write strobe.
  input wire logic regRd, // Read strobe.
  output logic [7:0] regRdata, // Read data, one cycle after the strobe.
  input wire logic [15:0] busAddr, // Core address bus.
  input wire logic [15:0] busData, // Core data bus.
  input wire logic [5:0] progPage, // Program page select bits.
  input wire logic pageAccess, // Access falls in the paged window.
  input wire logic busValid, // Bus access this cycle.
  input wire logic busRead, // High on read, low on write.
  output logic matchA, // Comparator A match, registered.
  output logic matchB // Comparator B match, registered.
);
  import bkq_pkg::*;

  typedef struct packed {
    bkq_byte_t ctrl;
    logic bkpMode;
    logic fullMode;
    bkq_page_t aExt;
    bkq_word_t aVal;
    bkq_page_t bExt;
    bkq_word_t bVal;
    bkq_byte_t rdata;
    logic matchA;
    logic matchB;
  } bkq_state_t;

  bkq_state_t state_r;
  bkq_state_t state_nxt;
  bkq_cmp_if cmpA ();
  bkq_cmp_if cmpB ();

  // Read mux shared by the bus path.
  function automatic bkq_byte_t readReg(input bkq_state_t s, input bkq_addr_t a);
    bkq_byte_t v;
    v = 8'h00;
    case (a)
      `BKQ_OFF_MASK_RW: v = s.ctrl;
      `BKQ_OFF_MODE: v = {6'h00, s.bkpMode, s.fullMode};
      `BKQ_OFF_A_EXT: v = {2'b00, s.aExt};
      `BKQ_OFF_A_HIGH: v = s.aVal[15:8];
      `BKQ_OFF_A_LOW: v = s.aVal[7:0];
      `BKQ_OFF_B_EXT: v = {2'b00, s.bExt};
      `BKQ_OFF_B_HIGH: v = s.bVal[15:8];
      `BKQ_OFF_B_LOW: v = s.bVal[7:0];
      `BKQ_OFF_STATUS: v = {6'h00, s.matchB, s.matchA};
      default: v = 8'h00;
    endcase
    return v;
  endfunction

  // Register writes; unmapped writes are dropped and unmapped reads give zero.
  always_comb begin
    state_nxt = state_r;
    state_nxt.matchA = cmpA.hit;
    state_nxt.matchB = cmpB.hit;
    if (regRd) begin
      state_nxt.rdata = readReg(state_r, regAddr);
    end
    if (regWr) begin
      case (regAddr)
        `BKQ_OFF_MASK_RW: state_nxt.ctrl = regWdata;
        `BKQ_OFF_MODE: begin
          state_nxt.bkpMode = regWdata[`BKQ_BIT_MODE_BKP];
          state_nxt.fullMode = regWdata[`BKQ_BIT_MODE_FULL];
        end
        `BKQ_OFF_A_EXT: state_nxt.aExt = regWdata[5:0];
        `BKQ_OFF_A_HIGH: state_nxt.aVal[15:8] = regWdata;
        `BKQ_OFF_A_LOW: state_nxt.aVal[7:0] = regWdata;
        `BKQ_OFF_B_EXT: state_nxt.bExt = regWdata[5:0];
        `BKQ_OFF_B_HIGH: state_nxt.bVal[15:8] = regWdata;
        `BKQ_OFF_B_LOW: state_nxt.bVal[7:0] = regWdata;
        default: state_nxt.ctrl = state_r.ctrl;
      endcase
    end
  end

  // Comparator A settings; debug mode clears its byte masks.
  always_comb begin
    cmpA.cfg.ext = state_r.aExt;
    cmpA.cfg.value = state_r.aVal;
    cmpA.cfg.maskHigh = state_r.bkpMode && state_r.ctrl[`BKQ_BIT_AMH];
    cmpA.cfg.maskLow = state_r.bkpMode && state_r.ctrl[`BKQ_BIT_AML];
    cmpA.cfg.dirEn = state_r.ctrl[`BKQ_BIT_A_DIR_EN];
    cmpA.cfg.dirVal = state_r.ctrl[`BKQ_BIT_A_DIR];
    cmpA.cfg.dataMode = 1'b0;
  end

  // Comparator B settings; full mode turns it into the data comparator.
  always_comb begin
    cmpB.cfg.ext = state_r.bExt;
    cmpB.cfg.value = state_r.bVal;
    cmpB.cfg.maskHigh = state_r.ctrl[`BKQ_BIT_BMH];
    cmpB.cfg.maskLow = state_r.ctrl[`BKQ_BIT_BML];
    cmpB.cfg.dirEn = !state_r.fullMode && state_r.ctrl[`BKQ_BIT_B_DIR_EN];
    cmpB.cfg.dirVal = state_r.ctrl[`BKQ_BIT_B_DIR];
    cmpB.cfg.dataMode = state_r.fullMode;
  end

  bkq_matcher uMatchA (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .link(cmpA.cmp),
    .busAddr(busAddr),
    .busData(busData),
    .progPage(progPage),
    .pageAccess(pageAccess),
    .busValid(busValid),
    .busRead(busRead)
  );

  bkq_matcher uMatchB (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .link(cmpB.cmp),
    .busAddr(busAddr),
    .busData(busData),
    .progPage(progPage),
    .pageAccess(pageAccess),
    .busValid(busValid),
    .busRead(busRead)
  );

  // The outputs add one stage after the matchers so each comes straight from a flop.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= '0;
      state_r.ctrl <= `BKQ_RST_REG;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign regRdata = state_r.rdata;
  assign matchA = state_r.matchA;
  assign matchB = state_r.matchB;

  property p_full_ignores_bdir;
    @(posedge sys_clk) disable iff (!rst_n) state_r.fullMode |-> !cmpB.cfg.dirEn;
  endproperty
  a_full_ignores_bdir: assert property (p_full_ignores_bdir) else $error("B direction used.");
  property p_dbg_masks;
    @(posedge sys_clk) disable iff (!rst_n)
      !state_r.bkpMode |-> !cmpA.cfg.maskHigh && !cmpA.cfg.maskLow;
  endproperty
  a_dbg_masks: assert property (p_dbg_masks) else $error("A masks not forced.");
  property p_match_pipe;
    @(posedge sys_clk) disable iff (!rst_n) cmpA.hit |=> matchA;
  endproperty
  a_match_pipe: assert property (p_match_pipe) else $error("Match A lost.");
endmodule

// ==== bkq_core_model.sv ====
// Behavioural core bus that issues one access at a time toward the qualifier.
`timescale 1ns/1ps
module bkq_core_model (
  input wire logic sys_clk, // Core bus clock.
  output logic [15:0] busAddr, // Core address bus.
  output logic [15:0] busData, // Core data bus.
  output logic [5:0] progPage, // Program page bits.
  output logic pageAccess, // Paged access flag.
  output logic busValid, // Access this cycle.
  output logic busRead // High on read.
);
  // Idle lines start quiet.
  initial begin
    busAddr = 16'h0000;
    busData = 16'h0000;
    progPage = 6'h00;
    pageAccess = 1'b0;
    busValid = 1'b0;
    busRead = 1'b0;
  end

  // Between accesses the lines show the inverse, so stale values never match by luck.
  task automatic access(input logic [15:0] a, d, input logic [5:0] pg, input logic pgd, r);
    @(posedge sys_clk);
    busAddr <= a;
    busData <= d;
    progPage <= pg;
    pageAccess <= pgd;
    busRead <= r;
    busValid <= 1'b1;
    @(posedge sys_clk);
    busAddr <= ~a;
    busData <= ~d;
    progPage <= ~pg;
    pageAccess <= ~pgd;
    busRead <= ~r;
    busValid <= 1'b0;
  endtask
endmodule

// ==== bkq_qualifier_tb_top.sv ====
// Self-checking bench for the breakpoint match qualifier.
`timescale 1ns/1ps
module bkq_qualifier_tb_top;
  import bkq_pkg::*;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  bkq_addr_t regAddr = 4'h0;
  bkq_byte_t regWdata = 8'h00;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic [7:0] regRdata;
  logic [15:0] busAddr, busData;
  logic [5:0] progPage;
  logic pageAccess, busValid, busRead, matchA, matchB;
  int error_cnt = 0;
  int check_count = 0;
  logic [7:0] cfg [8];
  logic [15:0] pA [7] = '{16'h2345, 16'h5A00, 16'h2745, 16'h6345, 16'h6345, 16'hDA3C, 16'h5A3C};
  logic [15:0] pD [7] = '{16'h5A3C, 16'h5A00, 16'h003C, 16'hFF3C, 16'h5AFF, 16'h0000, 16'h5A3C};
  logic [5:0] pP [7] = '{6'h0A, 6'h0A, 6'h0A, 6'h0A, 6'h0B, 6'h0A, 6'h15};
  logic [6:0] pPg = 7'h78; // Probes 3 to 6 are paged.
  logic [6:0] pRd = 7'h7B; // Probe 2 is the only write.

  // Free-running 20 MHz clock.
  always #25 sys_clk = ~sys_clk;

  bkq_qualifier dut (.sys_clk(sys_clk), .rst_n(rst_n), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
    .busAddr(busAddr), .busData(busData), .progPage(progPage), .pageAccess(pageAccess),
    .busValid(busValid), .busRead(busRead), .matchA(matchA), .matchB(matchB));

  bkq_core_model core (.sys_clk(sys_clk), .busAddr(busAddr), .busData(busData),
    .progPage(progPage), .pageAccess(pageAccess), .busValid(busValid), .busRead(busRead));

  task automatic finish_test();
    if (error_cnt == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic cmp(input string what, input logic [15:0] exp, got);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge sys_clk);
    regWr <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge sys_clk);
    regRd <= 1'b0;
    #1 d = regRdata;
  endtask

  task automatic set_cfg();
    for (int i = 0; i < 8; i++) begin
      wr(i[3:0], cfg[i]);
    end
  endtask

  // Expected hit worked out from the shadow settings; b picks comparator B.
  function automatic logic exp_hit(input logic b, input logic [15:0] a, d,
    input logic [5:0] pg, input logic pgd, r);
    logic [1:0] m;
    logic [15:0] v;
    logic dm, en, ok;
    m = b ? cfg[0][5:4] : (cfg[1][1] ? cfg[0][7:6] : 2'b00);
    v = b ? {cfg[6], cfg[7]} : {cfg[3], cfg[4]};
    dm = b & cfg[1][0];
    en = b ? (!dm && cfg[0][1]) : cfg[0][3];
    if (dm) begin
      ok = (m[1] || v[15:8] == d[15:8]) && (m[0] || v[7:0] == d[7:0]);
    end else begin
      ok = (m[0] || v[7:0] == a[7:0]);
      if (pgd) begin
        ok = ok && (b ? cfg[5][5:0] : cfg[2][5:0]) == pg && ((m == 2'b11) || v[13:8] == a[13:8]);
      end else begin
        ok = ok && ((m == 2'b11) || v[15:8] == a[15:8]);
      end
    end
    return ok && (!en || r == (b ? cfg[0][0] : cfg[0][2]));
  endfunction

  // One access, then both matches in the cycle after the matcher stage.
  // The access is sampled at the edge on which the model lowers it; the
  // match flops follow one edge later and stand for that cycle only.
  task automatic probe(input logic [15:0] a, d, input logic [5:0] pg, input logic pgd, r);
    logic ea, eb;
    ea = exp_hit(1'b0, a, d, pg, pgd, r);
    eb = exp_hit(1'b1, a, d, pg, pgd, r);
    core.access(a, d, pg, pgd, r);
    @(posedge sys_clk);
    #1;
    cmp("matchA", 16'(ea), 16'(matchA));
    cmp("matchB", 16'(eb), 16'(matchB));
  endtask

  task automatic t_regs();
    logic [7:0] d;
    for (int i = 0; i < 9; i++) begin
      rd(i[3:0], d);
      cmp("reset value", 16'h0000, 16'(d));
    end
    wr(4'h0, 8'hA5);
    rd(4'h0, d);
    cmp("control readback", 16'h00A5, 16'(d));
    wr(4'hC, 8'hFF);
    rd(4'hC, d);
    cmp("unmapped read", 16'h0000, 16'(d));
    rd(4'h0, d);
    cmp("control after unmapped write", 16'h00A5, 16'(d));
  endtask

  // Every mode and mask pair against the probe table.
  task automatic t_table();
    cfg = '{8'h00, 8'h00, 8'h0A, 8'h23, 8'h45, 8'h0A, 8'h5A, 8'h3C};
    for (int md = 0; md < 4; md++) begin
      for (int m = 0; m < 4; m++) begin
        cfg[0] = {m[1:0], m[1:0], 4'h3};
        cfg[1] = md[7:0];
        set_cfg();
        for (int i = 0; i < 7; i++) begin
          probe(pA[i], pD[i], pP[i], pPg[i], pRd[i]);
        end
      end
    end
  endtask

  // All direction settings with reads and writes in dual breakpoint mode.
  task automatic t_dir();
    cfg[1] = 8'h02;
    for (int c = 0; c < 16; c++) begin
      cfg[0] = {4'h0, c[3:0]};
      set_cfg();
      for (int r = 0; r < 2; r++) begin
        probe(16'h2345, 16'h0000, 6'h00, 1'b0, r[0]);
        probe(16'h5A3C, 16'h0000, 6'h00, 1'b0, r[0]);
      end
    end
  endtask

  // Main sequence after the reset hold.
  initial begin
    repeat (12) @(posedge sys_clk);
    rst_n <= 1'b1;
    t_regs();
    t_table();
    t_dir();
    finish_test();
  end

  // Watchdog well beyond the expected run length.
  initial begin
    #(20000 * 50);
    error_cnt++;
    finish_test();
  end
endmodule
